// >>> design/mvpc_top.sv
// Measured-value peak tracker and limit comparator for one channel, APB slave.
//
// Notes on behaviour
// [R1] Maximum and minimum track continuously whatever mode is selected.
// [R2] Peak-to-peak equals maximum minus minimum.
// [R3] Four modes choose the value that is output and judged.
// [R4] Without reference, preset recall loads the preset into the current value.
// [R5] First master preset after reference capture stores the reference offset.
// [R6] Later reference captures apply the stored offset automatically.
// [R7] Without reference, measuring starts at power-up, counting incrementally.
// [R8] With reference, measuring starts only after the reference mark passes.
// [R9] Host sends setup open, preset value, setup close in that order.
// [R10] Clear command drops the stored offset; host repeats the acquisition.
// [R11] Reset forces current, maximum, minimum and peak-to-peak to zero.
// [R12] Reset cancels an established or in-progress reference point.
// [R13] Start restarts peak tracking at once from the present position.
// [R14] Start keeps current, loads maximum and minimum with it, recomputes peak-to-peak.
// [R15] Judgment is U above upper, L below lower, otherwise G.
// [R16] The judgment applies to the selected mode's value and travels with it.
// [R17] Four limit sets are held; the active set may change anytime.
// [R18] Hold input in current mode freezes output value and judgment.
// [R19] The output latch has no effect in peak modes.
// [R20] Pause stops peak updates while the current value keeps updating.
// [R21] Pause in a peak mode keeps output value and judgment unchanged.
// [R22] Configuration is saved to and restored from non-volatile storage.
// [R23] All values are signed integers in sensor resolution units.
`timescale 1ns/1ps
`default_nettype none
module mvpc_top
    import mvpc_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`MVPC_AW-1:0] paddr,
    input wire logic [`MVPC_DW-1:0] pwdata,
    output logic [`MVPC_DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Sensor counts and reference mark
    input wire logic [`MVPC_DW-1:0] cnt_value,
    input wire logic ref_mark,
    // Parallel control inputs
    input wire logic start_hold_in,
    input wire logic preset_recall_in,
    input wire logic reset_in,
    // Non-volatile store
    input wire logic nv_restore_valid,
    input wire mvpc_nv_t nv_restore,
    output logic nv_save,
    output mvpc_nv_t nv_image,
    // Judged output
    output logic [`MVPC_DW-1:0] meas_value,
    output mvpc_jg_t meas_judge,
    output logic limit_fail,
    output logic hold_active,
    output logic measuring
);

    // ------------------------------------------------------------------------
    // Event decode
    // ------------------------------------------------------------------------
    mvpc_state_t s_q;
    mvpc_state_t s_d;
    logic wr_en;
    logic rd_setup;
    logic [`MVPC_CMD_W-1:0] cmd;
    logic ref_en;
    logic hold_cfg;
    logic pause;
    mvpc_mode_t mode;
    logic [1:0] set_idx;
    logic rst_evt;
    logic start_evt;
    logic recall_evt;
    logic quiet;
    logic freeze;
    logic [`MVPC_DW-1:0] sel_v;
    logic [`MVPC_DW-1:0] up_v;
    logic [`MVPC_DW-1:0] lo_v;
    mvpc_jg_t jg_now;

    assign wr_en = psel & penable & s_q.pready & pwrite;
    assign rd_setup = psel & ~penable;
    assign cmd = (wr_en && paddr == `MVPC_A_CMD) ? pwdata[`MVPC_CMD_W-1:0] : '0;
    assign ref_en = s_q.nv.ctrl[`MVPC_C_REF];
    assign hold_cfg = s_q.nv.ctrl[`MVPC_C_HOLD];
    assign pause = s_q.nv.ctrl[`MVPC_C_PAUSE];
    assign mode = mvpc_mode_t'(s_q.nv.ctrl[`MVPC_C_MODE +: 2]);
    assign set_idx = s_q.nv.ctrl[`MVPC_C_SET +: 2];
    assign rst_evt = reset_in | cmd[`MVPC_K_RESET];
    assign recall_evt = preset_recall_in | cmd[`MVPC_K_RECALL];
    // The start input is edge-sensed so a held level restarts tracking once.
    assign start_evt = (~hold_cfg & start_hold_in & ~s_q.start_prev) | cmd[`MVPC_K_START];
    assign quiet = ~nv_restore_valid & ~wr_en;

    // ------------------------------------------------------------------------
    // Mode select and comparator
    // ------------------------------------------------------------------------
    // [R3] Mode value select.
    always_comb begin
        case (mode)
            MVPC_MD_MAX: sel_v = s_q.maxv;
            MVPC_MD_MIN: sel_v = s_q.minv;
            MVPC_MD_PP: sel_v = s_q.ppv;
            default: sel_v = s_q.cur;
        endcase
    end

    // [R17] Active limit set.
    assign up_v = s_q.upper[set_idx];
    assign lo_v = s_q.lower[set_idx];

    // [R15] Signed limit judgment.
    assign jg_now = ($signed(sel_v) > $signed(up_v)) ? MVPC_JG_UP :
                    ($signed(sel_v) < $signed(lo_v)) ? MVPC_JG_LOW : MVPC_JG_GO;

    // [R18] Latch applies only in current mode; [R19] never in peak modes.
    // [R21] Pause freezes the output in peak modes.
    assign freeze = (hold_cfg & start_hold_in & (mode == MVPC_MD_CUR)) |
                    (pause & (mode != MVPC_MD_CUR));

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        logic [`MVPC_DW-1:0] rel;
        logic [`MVPC_DW-1:0] nmax;
        logic [`MVPC_DW-1:0] nmin;
        logic entering;
        rel = '0;
        nmax = '0;
        nmin = '0;
        entering = 1'b0;
        s_d = s_q;
        s_d.nv_save = 1'b0;
        s_d.pready = 1'b0;
        s_d.pslverr = 1'b0;
        s_d.start_prev = start_hold_in;

        // [R22] Restore of saved configuration.
        if (nv_restore_valid) begin
            s_d.nv = nv_restore;
            s_d.st = nv_restore.ctrl[`MVPC_C_REF] ? MVPC_ST_WAIT : MVPC_ST_MEAS;
        end

        // Register writes take effect at the access edge.
        if (wr_en) begin
            if (paddr == `MVPC_A_CTRL) begin
                s_d.nv.ctrl = pwdata[`MVPC_CTRL_W-1:0];
                if (!pwdata[`MVPC_C_REF]) begin
                    s_d.st = MVPC_ST_MEAS;
                end else if (!ref_en) begin
                    s_d.st = MVPC_ST_WAIT;
                end
            end else if (paddr == `MVPC_A_PRESET) begin
                if (s_q.setup_open) begin
                    s_d.nv.preset = pwdata;
                end
            end else if (paddr >= `MVPC_A_LIM_LO && paddr <= `MVPC_A_LIM_HI) begin
                for (int i = 0; i < `MVPC_LIM_N; i++) begin
                    if (paddr[`MVPC_LIM_IDX +: 2] == 2'(i)) begin
                        if (paddr[`MVPC_LIM_HL]) begin
                            s_d.lower[i] = pwdata;
                        end else begin
                            s_d.upper[i] = pwdata;
                        end
                    end
                end
            end
        end

        // [R9] Setup window gates preset writes until close.
        if (cmd[`MVPC_K_OPEN]) begin
            s_d.setup_open = 1'b1;
        end

        // [R10] Clear stored offset.
        if (cmd[`MVPC_K_CLROFF]) begin
            s_d.nv.ref_ok = 1'b0;
            s_d.nv.ref_off = `MVPC_ZERO;
            s_d.nv_save = 1'b1;
        end

        // Position adjustment: current value is the sensor count plus adj.
        rel = cnt_value + s_q.adj;
        if (rst_evt) begin
            // [R11] Zero current value.
            s_d.adj = `MVPC_ZERO - cnt_value;
            // [R12] Cancel reference point.
            if (s_d.nv.ctrl[`MVPC_C_REF]) begin
                s_d.st = MVPC_ST_WAIT;
            end
        end else if (s_q.st == MVPC_ST_WAIT) begin
            // [R8] Wait for reference mark.
            if (ref_mark && ref_en) begin
                s_d.st = MVPC_ST_MEAS;
                // [R6] Apply stored offset.
                s_d.adj = (s_q.nv.ref_ok ? s_q.nv.ref_off : `MVPC_ZERO) - cnt_value;
            end
        end else if (cmd[`MVPC_K_CLOSE] && s_q.setup_open && ref_en && !s_q.nv.ref_ok) begin
            // [R5] Master preset generates the offset.
            s_d.nv.ref_off = s_q.nv.preset - rel;
            s_d.nv.ref_ok = 1'b1;
            s_d.adj = s_q.adj + (s_q.nv.preset - rel);
        end else if (recall_evt && !ref_en) begin
            // [R4] Recall preset into current value.
            s_d.adj = s_q.nv.preset - cnt_value;
        end

        if (cmd[`MVPC_K_CLOSE] && s_q.setup_open) begin
            s_d.setup_open = 1'b0;
            s_d.nv_save = 1'b1;
        end

        // [R7] [R23] Signed incremental count.
        s_d.cur = cnt_value + s_d.adj;

        // Peak tracking runs only while measuring.
        entering = (s_d.st == MVPC_ST_MEAS) && (s_q.st != MVPC_ST_MEAS);
        nmax = ($signed(s_d.cur) > $signed(s_q.maxv)) ? s_d.cur : s_q.maxv;
        nmin = ($signed(s_d.cur) < $signed(s_q.minv)) ? s_d.cur : s_q.minv;
        if (rst_evt) begin
            // [R11] Zero the peaks.
            s_d.maxv = `MVPC_ZERO;
            s_d.minv = `MVPC_ZERO;
            s_d.ppv = `MVPC_ZERO;
        end else if (s_d.st == MVPC_ST_MEAS && (start_evt || entering)) begin
            // [R13] [R14] Restart peaks at present position.
            s_d.maxv = s_d.cur;
            s_d.minv = s_d.cur;
            s_d.ppv = `MVPC_ZERO;
        end else if (s_q.st == MVPC_ST_MEAS && !pause) begin
            // [R1] [R20] Continuous peak update unless paused.
            s_d.maxv = nmax;
            s_d.minv = nmin;
            // [R2] Peak-to-peak from new extremes.
            s_d.ppv = nmax - nmin;
        end

        // [R16] Output value carries its own judgment.
        s_d.frz = freeze;
        if (!freeze) begin
            s_d.outv = sel_v;
            s_d.outj = jg_now;
            s_d.fail = (jg_now != MVPC_JG_GO);
        end

        // APB: zero wait states, read data captured in the setup cycle.
        if (rd_setup) begin
            s_d.pready = 1'b1;
            s_d.prdata = `MVPC_ZERO;
            if (paddr == `MVPC_A_CTRL) begin
                s_d.prdata = 32'(s_q.nv.ctrl);
            end else if (paddr == `MVPC_A_CMD) begin
                s_d.prdata = `MVPC_ZERO;
            end else if (paddr == `MVPC_A_PRESET) begin
                s_d.prdata = s_q.nv.preset;
                s_d.pslverr = pwrite & ~s_q.setup_open;
            end else if (paddr == `MVPC_A_STATUS) begin
                s_d.prdata = 32'({s_q.frz, s_q.fail, s_q.setup_open, s_q.nv.ref_ok,
                                  s_q.outj, s_q.st});
            end else if (paddr == `MVPC_A_CUR) begin
                s_d.prdata = s_q.cur;
            end else if (paddr == `MVPC_A_MAX) begin
                s_d.prdata = s_q.maxv;
            end else if (paddr == `MVPC_A_MIN) begin
                s_d.prdata = s_q.minv;
            end else if (paddr == `MVPC_A_PP) begin
                s_d.prdata = s_q.ppv;
            end else if (paddr == `MVPC_A_OUT) begin
                s_d.prdata = s_q.outv;
            end else if (paddr == `MVPC_A_REFOFF) begin
                s_d.prdata = s_q.nv.ref_off;
            end else if (paddr >= `MVPC_A_LIM_LO && paddr <= `MVPC_A_LIM_HI
                         && paddr[1:0] == 2'b00) begin
                s_d.prdata = paddr[`MVPC_LIM_HL] ? s_q.lower[paddr[`MVPC_LIM_IDX +: 2]]
                                                 : s_q.upper[paddr[`MVPC_LIM_IDX +: 2]];
            end else begin
                s_d.pslverr = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.st <= MVPC_ST_MEAS;
            s_q.nv.ctrl <= `MVPC_CTRL_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign nv_save = s_q.nv_save;
    assign nv_image = s_q.nv;
    assign meas_value = s_q.outv;
    assign meas_judge = s_q.outj;
    assign limit_fail = s_q.fail;
    assign hold_active = s_q.frz;
    assign measuring = (s_q.st == MVPC_ST_MEAS);

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_pp_diff: assert property (s_q.ppv == s_q.maxv - s_q.minv) // [R2]
        else $error("peak-to-peak differs from max minus min");

    chk_max_grows: assert property ( // [R1]
        (s_q.st == MVPC_ST_MEAS && !pause && !rst_evt && !start_evt && quiet)
        |=> $signed(s_q.maxv) >= $signed($past(s_q.maxv))
            && $signed(s_q.minv) <= $signed($past(s_q.minv)))
        else $error("peaks moved the wrong way");

    chk_reset_zero: assert property (rst_evt |=> // [R11]
        s_q.cur == `MVPC_ZERO && s_q.maxv == `MVPC_ZERO && s_q.minv == `MVPC_ZERO)
        else $error("reset did not zero the values");

    chk_start_load: assert property ( // [R14]
        (start_evt && !rst_evt && s_q.st == MVPC_ST_MEAS && quiet)
        |=> s_q.maxv == s_q.cur && s_q.minv == s_q.cur && s_q.ppv == `MVPC_ZERO)
        else $error("start did not load peaks");

    chk_judge_up: assert property ( // [R15]
        (!freeze && $signed(sel_v) > $signed(up_v)) |=> meas_judge == MVPC_JG_UP && limit_fail)
        else $error("value above upper not judged U");

    chk_judge_low: assert property ( // [R15]
        (!freeze && $signed(sel_v) < $signed(lo_v) && $signed(sel_v) <= $signed(up_v))
        |=> meas_judge == MVPC_JG_LOW && limit_fail)
        else $error("value below lower not judged L");

    chk_judge_go: assert property ( // [R15]
        (!freeze && $signed(sel_v) >= $signed(lo_v) && $signed(sel_v) <= $signed(up_v))
        |=> meas_judge == MVPC_JG_GO && !limit_fail)
        else $error("value inside limits not judged G");

    chk_out_follow: assert property (!freeze |=> // [R16]
        meas_value == $past(sel_v) && meas_judge == $past(jg_now))
        else $error("output does not follow selected value");

    chk_latch_hold: assert property (freeze ##1 freeze |-> // [R18]
        $stable(meas_value) && $stable(meas_judge))
        else $error("frozen output changed");

    chk_pause_peak: assert property ( // [R20]
        (pause && s_q.st == MVPC_ST_MEAS && !rst_evt && !start_evt && quiet)
        |=> $stable(s_q.maxv) && $stable(s_q.minv))
        else $error("peaks updated during pause");

    chk_wait_ref: assert property ( // [R8]
        (s_q.st == MVPC_ST_WAIT && !ref_mark && quiet) |=> s_q.st == MVPC_ST_WAIT)
        else $error("left reference wait without mark");

    chk_ref_apply: assert property ( // [R6]
        (s_q.st == MVPC_ST_WAIT && ref_en && ref_mark && s_q.nv.ref_ok && !rst_evt && quiet)
        |=> s_q.cur == $past(s_q.nv.ref_off))
        else $error("stored offset not applied at capture");

    chk_preset_gate: assert property ( // [R9]
        (wr_en && paddr == `MVPC_A_PRESET && !s_q.setup_open && !nv_restore_valid)
        |=> $stable(s_q.nv.preset))
        else $error("preset written outside setup window");

    chk_offset_clear: assert property ( // [R10]
        (cmd[`MVPC_K_CLROFF] && !cmd[`MVPC_K_CLOSE])
        |=> !s_q.nv.ref_ok && s_q.nv.ref_off == `MVPC_ZERO)
        else $error("offset not cleared on command");

    chk_apb_ready: assert property (rd_setup |=> pready ##1 (pready == $past(rd_setup)))
        else $error("APB answer not in access cycle");

endmodule // mvpc_top
`default_nettype wire

// >>> include/mvpc_params.svh
// Register map, field positions, reset values and widths of the measured-value comparator.
`ifndef MVPC_PARAMS_SVH
`define MVPC_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define MVPC_A_CTRL 12'h000
`define MVPC_A_CMD 12'h004
`define MVPC_A_PRESET 12'h008
`define MVPC_A_STATUS 12'h00C
`define MVPC_A_CUR 12'h010
`define MVPC_A_MAX 12'h014
`define MVPC_A_MIN 12'h018
`define MVPC_A_PP 12'h01C
`define MVPC_A_OUT 12'h020
`define MVPC_A_REFOFF 12'h024
`define MVPC_A_LIM_LO 12'h040
`define MVPC_A_LIM_HI 12'h05C

// ----------------------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------------------
`define MVPC_DW 32
`define MVPC_AW 12
`define MVPC_CTRL_W 7
`define MVPC_C_REF 0
`define MVPC_C_MODE 1
`define MVPC_C_SET 3
`define MVPC_C_HOLD 5
`define MVPC_C_PAUSE 6
`define MVPC_CMD_W 6
`define MVPC_K_RECALL 0
`define MVPC_K_RESET 1
`define MVPC_K_START 2
`define MVPC_K_OPEN 3
`define MVPC_K_CLOSE 4
`define MVPC_K_CLROFF 5
`define MVPC_LIM_N 4
`define MVPC_LIM_IDX 3
`define MVPC_LIM_HL 2

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define MVPC_CTRL_RST 7'h00
`define MVPC_ZERO 32'h0000_0000

`endif

// >>> include/mvpc_pkg.sv
// Types shared by the measured-value comparator.
`include "mvpc_params.svh"
package mvpc_pkg;

    typedef enum logic [1:0] {
        MVPC_ST_WAIT = 2'b01,
        MVPC_ST_MEAS = 2'b10
    } mvpc_st_t;

    typedef enum logic [1:0] {
        MVPC_MD_CUR = 2'h0,
        MVPC_MD_MAX = 2'h1,
        MVPC_MD_MIN = 2'h2,
        MVPC_MD_PP = 2'h3
    } mvpc_mode_t;

    typedef enum logic [1:0] {
        MVPC_JG_GO = 2'h0,
        MVPC_JG_UP = 2'h1,
        MVPC_JG_LOW = 2'h2
    } mvpc_jg_t;

    typedef struct packed {
        logic [`MVPC_CTRL_W-1:0] ctrl;
        logic [`MVPC_DW-1:0] preset;
        logic [`MVPC_DW-1:0] ref_off;
        logic ref_ok;
    } mvpc_nv_t;

    typedef struct packed {
        mvpc_st_t st;
        mvpc_nv_t nv;
        logic [`MVPC_DW-1:0] adj;
        logic [`MVPC_DW-1:0] cur;
        logic [`MVPC_DW-1:0] maxv;
        logic [`MVPC_DW-1:0] minv;
        logic [`MVPC_DW-1:0] ppv;
        logic [`MVPC_DW-1:0] outv;
        mvpc_jg_t outj;
        logic fail;
        logic frz;
        logic setup_open;
        logic start_prev;
        logic nv_save;
        logic [`MVPC_LIM_N-1:0][`MVPC_DW-1:0] upper;
        logic [`MVPC_LIM_N-1:0][`MVPC_DW-1:0] lower;
        logic [`MVPC_DW-1:0] prdata;
        logic pready;
        logic pslverr;
    } mvpc_state_t;

endpackage

// >>> verification/mvpc_host_model.sv
// Host model: issues register commands over APB.
`timescale 1ns/1ps
`default_nettype none
module mvpc_host_model
    import mvpc_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB master
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [`MVPC_AW-1:0] paddr,
    output logic [`MVPC_DW-1:0] pwdata,
    input wire logic [`MVPC_DW-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    int n_to = 0;
    initial begin
        psel = 0;
        penable = 0;
        pwrite = 0;
        paddr = 0;
        pwdata = 0;
    end
    // ------------------------------------------------------------------
    // One transfer; waits for pready under a bound.
    // ------------------------------------------------------------------
    task apb(input logic w, input logic [`MVPC_AW-1:0] a, input logic [`MVPC_DW-1:0] d,
             output logic [`MVPC_DW-1:0] r, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_to++;
        end
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task master(input logic [`MVPC_DW-1:0] v);
        logic [`MVPC_DW-1:0] r;
        logic e;
        apb(1, `MVPC_A_CMD, 32'h0000_0008, r, e);
        apb(1, `MVPC_A_PRESET, v, r, e);
        apb(1, `MVPC_A_CMD, 32'h0000_0010, r, e);
    endtask
endmodule // mvpc_host_model
`default_nettype wire

// >>> verification/tb_top.sv
// Self-checking testbench of the measured-value comparator.
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import mvpc_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ref_mark, start_hold_in;
    logic preset_recall_in, reset_in, nv_save, limit_fail, hold_active, measuring;
    logic [`MVPC_AW-1:0] paddr;
    logic [`MVPC_DW-1:0] pwdata, prdata, cnt_value, meas_value;
    mvpc_nv_t nv_image;
    mvpc_jg_t meas_judge;
    logic nv_restore_valid;
    mvpc_nv_t nv_restore;
    int n_fail = 0;
    int num_checks = 0;
    initial begin
        pclk = 0;
        forever #2.5 pclk = ~pclk;
    end
    mvpc_host_model i_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    mvpc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cnt_value(cnt_value), .ref_mark(ref_mark),
        .start_hold_in(start_hold_in), .preset_recall_in(preset_recall_in),
        .reset_in(reset_in), .nv_restore_valid(nv_restore_valid), .nv_restore(nv_restore),
        .nv_save(nv_save), .nv_image(nv_image), .meas_value(meas_value),
        .meas_judge(meas_judge), .limit_fail(limit_fail), .hold_active(hold_active),
        .measuring(measuring));
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task finish_test;
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task chk(input logic [`MVPC_DW-1:0] s, input logic [`MVPC_DW-1:0] e);
        num_checks++;
        if (s !== e) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] ex,
              input logic ee);
        logic [31:0] r;
        logic e;
        i_host.apb(w, a, d, r, e);
        if (i_host.n_to != 0) begin
            n_fail++;
            finish_test;
        end
        chk(e, ee);
        if (!w) begin
            chk(r, ex);
        end
    endtask
    task rd(input logic [11:0] a, input logic [31:0] ex);
        xfer(0, a, 0, ex, 0);
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1, a, d, 0, 0);
    endtask
    task cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task mv(input int v);
        @(posedge pclk);
        cnt_value <= v;
        cyc(3);
    endtask
    task zero_at(input int v);
        mv(v);
        @(posedge pclk);
        reset_in <= 1;
        @(posedge pclk);
        reset_in <= 0;
        cyc(3);
    endtask
    task peaks(input int c, input int mx, input int mn, input int pp);
        rd(`MVPC_A_CUR, c);
        rd(`MVPC_A_MAX, mx);
        rd(`MVPC_A_MIN, mn);
        rd(`MVPC_A_PP, pp);
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task s_reset;
        rd(`MVPC_A_CTRL, 0);
        chk(measuring, 1);
        xfer(0, 12'h100, 0, 0, 1);
        xfer(1, `MVPC_A_PRESET, 5, 0, 1);
        nv_restore <= '{7'h06, 32'h0000_0007, 32'h0000_0000, 1'b0};
        nv_restore_valid <= 1;
        @(posedge pclk);
        nv_restore_valid <= 0;
        rd(`MVPC_A_CTRL, 32'h0000_0006);
        rd(`MVPC_A_PRESET, 32'h0000_0007);
    endtask
    task s_modes;
        int ex[4];
        zero_at(0);
        mv(30);
        mv(-10);
        mv(5);
        ex = '{5, 30, -10, 40};
        for (int m = 0; m < 4; m++) begin
            wr(`MVPC_A_CTRL, m << 1);
            cyc(3);
            chk(meas_value, ex[m]);
        end
        peaks(5, 30, -10, 40);
        @(posedge pclk);
        start_hold_in <= 1;
        cyc(3);
        start_hold_in <= 0;
        peaks(5, 5, 5, 0);
        wr(`MVPC_A_CMD, 2);
        cyc(3);
        peaks(0, 0, 0, 0);
    endtask
    task s_recall;
        zero_at(0);
        i_host.master(500);
        @(posedge pclk);
        chk(nv_save, 1);
        chk(nv_image.preset, 500);
        mv(40);
        preset_recall_in <= 1;
        @(posedge pclk);
        preset_recall_in <= 0;
        cyc(3);
        rd(`MVPC_A_CUR, 500);
    endtask
    task s_judge;
        int v[5];
        logic [1:0] j[5];
        zero_at(0);
        wr(`MVPC_A_LIM_LO + 8, 600);
        wr(`MVPC_A_LIM_LO + 12, 400);
        wr(`MVPC_A_CTRL, 32'h0000_0008);
        v = '{600, 601, 400, 399, 500};
        j = '{MVPC_JG_GO, MVPC_JG_UP, MVPC_JG_GO, MVPC_JG_LOW, MVPC_JG_GO};
        for (int i = 0; i < 5; i++) begin
            mv(v[i]);
            chk(meas_judge, j[i]);
            chk(limit_fail, j[i] != MVPC_JG_GO);
            chk(meas_value, v[i]);
        end
        wr(`MVPC_A_CTRL, 0);
        cyc(3);
        chk(meas_judge, MVPC_JG_UP);
    endtask
    task s_pause;
        zero_at(0);
        mv(10);
        wr(`MVPC_A_CTRL, 32'h0000_0042);
        mv(50);
        chk(meas_value, 10);
        chk(hold_active, 1);
        rd(`MVPC_A_CUR, 50);
        rd(`MVPC_A_MAX, 10);
        wr(`MVPC_A_CTRL, 32'h0000_0002);
        cyc(3);
        chk(meas_value, 50);
    endtask
    task s_hold;
        zero_at(0);
        wr(`MVPC_A_CTRL, 32'h0000_0020);
        mv(7);
        start_hold_in <= 1;
        mv(9);
        chk(meas_value, 7);
        wr(`MVPC_A_CTRL, 32'h0000_0022);
        mv(70);
        chk(meas_value, 70);
        start_hold_in <= 0;
    endtask
    task s_ref;
        zero_at(0);
        wr(`MVPC_A_CTRL, 1);
        zero_at(0);
        chk(measuring, 0);
        mv(0);
        ref_mark <= 1;
        @(posedge pclk);
        ref_mark <= 0;
        cyc(3);
        chk(measuring, 1);
        mv(20);
        i_host.master(100);
        cyc(3);
        rd(`MVPC_A_REFOFF, 80);
        rd(`MVPC_A_CUR, 100);
        zero_at(20);
        chk(measuring, 0);
        ref_mark <= 1;
        @(posedge pclk);
        ref_mark <= 0;
        cyc(3);
        rd(`MVPC_A_CUR, 80);
        wr(`MVPC_A_CMD, 32'h0000_0020);
        cyc(3);
        rd(`MVPC_A_REFOFF, 0);
    endtask
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        presetn = 0;
        cnt_value = 0;
        ref_mark = 0;
        start_hold_in = 0;
        preset_recall_in = 0;
        reset_in = 0;
        nv_restore_valid = 0;
        nv_restore = '0;
        cyc(20);
        presetn <= 1;
        s_reset;
        s_modes;
        s_recall;
        s_judge;
        s_pause;
        s_hold;
        s_ref;
        finish_test;
    end
endmodule // tb_top
`default_nettype wire
